// ### tb/nvp_program_erase_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvp_cfg.svh"

module nvp_program_erase_control_tb;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_i = 1'b1;
  logic special_mode_i = 1'b0;
  logic [15:0] avm_address_i = 16'h0000;
  logic avm_read_i = 1'b0;
  logic avm_write_i = 1'b0;
  logic [3:0] avm_byteenable_i = 4'h1;
  logic [31:0] avm_writedata_i = 32'h00000000;
  logic [31:0] avm_readdata_o;
  logic avm_waitrequest_o;
  logic hv_enable_o;
  logic latch_o;
  logic pump_rc_sel_o;
  logic [7:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;

  nvp_program_erase_control i_nvp_program_erase_control (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .por_i(por_i),
    .special_mode_i(special_mode_i),
    .avm_address_i(avm_address_i),
    .avm_read_i(avm_read_i),
    .avm_write_i(avm_write_i),
    .avm_byteenable_i(avm_byteenable_i),
    .avm_writedata_i(avm_writedata_i),
    .avm_readdata_o(avm_readdata_o),
    .avm_waitrequest_o(avm_waitrequest_o),
    .hv_enable_o(hv_enable_o),
    .latch_o(latch_o),
    .pump_rc_sel_o(pump_rc_sel_o)
  );

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avm_address_i <= a;
    avm_writedata_i <= {24'h000000, d};
    avm_write_i <= wr;
    avm_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avm_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      $display("MISMATCH waitrequest expected 0 seen %b", avm_waitrequest_o);
    end
    rd = avm_readdata_o[7:0];
    avm_write_i <= 1'b0;
    avm_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string name, input logic [15:0] a,
                       input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(name, rd, exp);
  endtask

  task automatic outchk(input logic l, input logic h, input logic p);
    @(negedge mclk_i);
    check("latch", {7'h00, latch_o}, {7'h00, l});
    check("hv", {7'h00, hv_enable_o}, {7'h00, h});
    check("pump", {7'h00, pump_rc_sel_o}, {7'h00, p});
  endtask

  // latch with mode, target write, voltage on, then clear
  task automatic prog_op(input logic [7:0] c, input logic [15:0] a,
                         input logic [7:0] d);
    wr(`NVP_CTRL_IDX, c);
    wr(a, d);
    wr(`NVP_CTRL_IDX, c | 8'h01);
    wr(`NVP_CTRL_IDX, 8'h00);
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // watchdog, well beyond the few hundred cycles the run needs
  // ---------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (15) @(posedge mclk_i);
    por_i <= 1'b0;
    @(posedge mclk_i);
    reset_i <= 1'b0;
    rdchk("prot", `NVP_PROT_IDX, 8'h1f);
    rdchk("ctrl", `NVP_CTRL_IDX, 8'h00);
    wr(`NVP_PROT_IDX, 8'h10);
    rdchk("prot", `NVP_PROT_IDX, 8'h10);
    wr(`NVP_PUMP_IDX, 8'h01);
    outchk(1'b0, 1'b0, 1'b1);
    wr(`NVP_PUMP_IDX, 8'h00);
    outchk(1'b0, 1'b0, 1'b0);
    // low byte lane disabled: the write must be dropped
    @(posedge mclk_i);
    avm_byteenable_i <= 4'h0;
    wr(`NVP_PUMP_IDX, 8'h01);
    avm_byteenable_i <= 4'h1;
    outchk(1'b0, 1'b0, 1'b0);
    rdchk("erased", `NVP_ARRAY_BASE + 16'h0005, 8'hff);
    wr(`NVP_CTRL_IDX, 8'h02);
    outchk(1'b1, 1'b0, 1'b0);
    rdchk("latched", `NVP_ARRAY_BASE + 16'h0005, 8'hff);
    // voltage refused until a target write has been seen
    wr(`NVP_CTRL_IDX, 8'h03);
    outchk(1'b1, 1'b0, 1'b0);
    wr(`NVP_ARRAY_BASE + 16'h0005, 8'ha5);
    wr(`NVP_CTRL_IDX, 8'h03);
    outchk(1'b1, 1'b1, 1'b0);
    wr(`NVP_CTRL_IDX, 8'h00);
    outchk(1'b0, 1'b0, 1'b0);
    rdchk("prog", `NVP_ARRAY_BASE + 16'h0005, 8'ha5);
    prog_op(8'h02, `NVP_ARRAY_BASE + 16'h0005, 8'h5a);
    rdchk("and", `NVP_ARRAY_BASE + 16'h0005, 8'h00);
    wr(`NVP_ARRAY_BASE + 16'h0007, 8'h00);
    rdchk("rom", `NVP_ARRAY_BASE + 16'h0007, 8'hff);
    wr(`NVP_CTRL_IDX, 8'h03);
    outchk(1'b0, 1'b0, 1'b0);
    rdchk("ctrl", `NVP_CTRL_IDX, 8'h00);
    wr(`NVP_CTRL_IDX, 8'h01);
    outchk(1'b0, 1'b0, 1'b0);
    prog_op(8'h1a, `NVP_ARRAY_BASE + 16'h0006, 8'h3c);
    rdchk("prog", `NVP_ARRAY_BASE + 16'h0006, 8'h3c);
    rdchk("near", `NVP_ARRAY_BASE + 16'h0007, 8'hff);
    prog_op(8'h16, `NVP_ARRAY_BASE + 16'h0006, 8'h00);
    rdchk("byte", `NVP_ARRAY_BASE + 16'h0006, 8'hff);
    rdchk("kept", `NVP_ARRAY_BASE + 16'h0005, 8'h00);
    prog_op(8'h02, `NVP_ARRAY_BASE + 16'h0011, 8'h00);
    prog_op(8'h0e, `NVP_ARRAY_BASE + 16'h001f, 8'h55);
    rdchk("row", `NVP_ARRAY_BASE + 16'h0011, 8'hff);
    rdchk("kept", `NVP_ARRAY_BASE + 16'h0005, 8'h00);
    // early window long gone: clears ignored, sets accepted
    repeat (64) @(posedge mclk_i);
    wr(`NVP_PROT_IDX, 8'h00);
    rdchk("prot", `NVP_PROT_IDX, 8'h10);
    wr(`NVP_PROT_IDX, 8'h01);
    rdchk("prot", `NVP_PROT_IDX, 8'h11);
    prog_op(8'h02, `NVP_ARRAY_BASE + 16'h001f, 8'h00);
    rdchk("blk0", `NVP_ARRAY_BASE + 16'h001f, 8'hff);
    prog_op(8'h02, `NVP_ARRAY_BASE + 16'h0020, 8'h33);
    rdchk("blk1", `NVP_ARRAY_BASE + 16'h0020, 8'h33);
    prog_op(8'h06, `NVP_ARRAY_BASE + 16'h0100, 8'h00);
    rdchk("bulk", `NVP_ARRAY_BASE + 16'h0020, 8'hff);
    rdchk("blk0", `NVP_ARRAY_BASE + 16'h0005, 8'h00);
    rdchk("opt", `NVP_OPT_IDX, 8'hff);
    prog_op(8'h02, `NVP_OPT_IDX, 8'hfe);
    rdchk("opt", `NVP_OPT_IDX, 8'hff);
    special_mode_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wr(`NVP_PROT_IDX, 8'h00);
    rdchk("prot", `NVP_PROT_IDX, 8'h00);
    wr(`NVP_PROT_IDX, 8'h1f);
    rdchk("prot", `NVP_PROT_IDX, 8'h1f);
    wr(`NVP_PROT_IDX, 8'h00);
    rdchk("prot", `NVP_PROT_IDX, 8'h00);
    prog_op(8'h02, `NVP_OPT_IDX, 8'hfe);
    rdchk("opt", `NVP_OPT_IDX, 8'hfe);
    rdchk("visible", `NVP_ARRAY_BASE + 16'h0020, 8'hff);
    do_reset();
    rdchk("hidden", `NVP_ARRAY_BASE + 16'h0020, 8'h00);
    rdchk("prot", `NVP_PROT_IDX, 8'h1f);
    wr(`NVP_PROT_IDX, 8'h00);
    prog_op(8'h16, `NVP_OPT_IDX, 8'h00);
    rdchk("opt", `NVP_OPT_IDX, 8'hff);
    do_reset();
    rdchk("visible", `NVP_ARRAY_BASE + 16'h0020, 8'hff);
    rdchk("unmapped", 16'h2000, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire

// ### verilog/nvp_cfg.svh
`ifndef NVP_CFG_SVH
`define NVP_CFG_SVH

// ---------------------------------------------------------------
// register word indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define NVP_CTRL_IDX 16'h103b
`define NVP_PROT_IDX 16'h1035
`define NVP_PUMP_IDX 16'h1039
`define NVP_OPT_IDX 16'h103f

// ---------------------------------------------------------------
// program control fields
// ---------------------------------------------------------------
`define NVP_B_VOLT 0
`define NVP_B_LATCH 1
`define NVP_B_ERASE 2
`define NVP_B_ROW 3
`define NVP_B_BYTE 4
`define NVP_CTRL_RESET 5'h00

// ---------------------------------------------------------------
// block protect fields
// ---------------------------------------------------------------
`define NVP_PROT_RESET 5'h1f
`define NVP_PROT_OPT 4
`define NVP_EARLY_CYCLES 7'h40

// ---------------------------------------------------------------
// array map and option register fields
// ---------------------------------------------------------------
`define NVP_ARRAY_BASE 16'hb600
`define NVP_WIDE_PAGE_OFF 12'h800
`define NVP_REG0_END 16'h0020
`define NVP_REG1_END 16'h0060
`define NVP_REG2_END 16'h00e0
`define NVP_QUARTER_SHIFT 9
`define NVP_ROW_SHIFT 4
`define NVP_ERASED 8'hff
`define NVP_OPT_VIS 0
`define NVP_OPT_BASE_HI 7
`define NVP_OPT_BASE_LO 4

`endif

// ### verilog/nvp_pkg.sv
`default_nettype none

package nvp_pkg;
  typedef enum logic {
    bus_idle,
    bus_answer
  } nvp_bus_state_type;
endpackage

`default_nettype wire

// ### verilog/nvp_program_erase_control.sv
// How it works
// - erased reads one; program only clears bits
// - latch clear: array reads, writes ignored
// - pump clock: E clock or RC oscillator
// - voltage needs latch, address write, then both
// - setting latch and voltage together sets neither
// - voltage bit written only while latch set
// - protect resets set; clearable first 64 cycles
// - setting protect bits always accepted
// - special modes: protect freely cleared and set
// - array mapped only while visible bit set
// - option protect blocks option program and erase
// - four protect bits guard 32/64/128/288 regions
// - wide array: quarters, base from option field
// - byte, row or bulk erase selection
// - latch set: array unreadable, bus held
// - voltage bit drives high voltage; clear reads
// - program ignores byte and row selects
// - option register erased and programmed anywhere
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "nvp_cfg.svh"

module nvp_program_erase_control #(
  parameter int ARRAY_BYTES = 512,
  parameter bit WIDE = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic por_i,
  // operating mode pin
  input wire logic special_mode_i,
  // avalon-mm slave
  input wire logic [15:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [3:0] avm_byteenable_i,
  input wire logic [31:0] avm_writedata_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  // array side controls
  output logic hv_enable_o,
  output logic latch_o,
  output logic pump_rc_sel_o
);

  localparam int AW = $clog2(ARRAY_BYTES);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  nvp_pkg::nvp_bus_state_type bus_state_reg;
  logic [31:0] rdata_reg;
  logic [4:0] ctrl_reg, ctrl_next;
  logic addr_seen_reg, tgt_opt_reg;
  logic [AW-1:0] tgt_idx_reg;
  logic [7:0] tgt_data_reg;
  logic [4:0] prot_reg;
  logic [6:0] early_cnt_reg;
  logic mode_meta_reg, mode_sync_reg;
  logic pump_clock_select_reg;
  logic [7:0] opt_cells_reg, opt_active_reg;
  logic [7:0] mem_reg [ARRAY_BYTES];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [15:0] array_base, offset_full;
  logic in_array, req, do_write, wr_ctrl, wr_prot, wr_pump, wr_target;
  logic [AW-1:0] mem_idx;
  logic early, exec;
  logic [7:0] wbyte, rd_byte;

  assign wbyte = avm_writedata_i[7:0];
  assign req = avm_read_i | avm_write_i;
  // base nibble comes from the active option value, not the cells
  assign array_base = WIDE ?
      {opt_active_reg[`NVP_OPT_BASE_HI:`NVP_OPT_BASE_LO],
       `NVP_WIDE_PAGE_OFF} : `NVP_ARRAY_BASE;
  assign offset_full = avm_address_i - array_base;
  assign in_array = opt_active_reg[`NVP_OPT_VIS] &&
      (offset_full < 16'(ARRAY_BYTES));
  assign mem_idx = offset_full[AW-1:0];
  assign do_write = avm_write_i && (bus_state_reg == nvp_pkg::bus_answer)
      && avm_byteenable_i[0];
  assign wr_ctrl = do_write && (avm_address_i == `NVP_CTRL_IDX);
  assign wr_prot = do_write && (avm_address_i == `NVP_PROT_IDX);
  assign wr_pump = do_write && (avm_address_i == `NVP_PUMP_IDX);
  assign wr_target = do_write &&
      (in_array || (avm_address_i == `NVP_OPT_IDX));
  assign early = early_cnt_reg < `NVP_EARLY_CYCLES;
  // the cells change when the high voltage is switched off
  assign exec = wr_ctrl && ctrl_reg[`NVP_B_VOLT] &&
      !ctrl_next[`NVP_B_VOLT];

  function automatic logic [1:0] region(input logic [AW-1:0] off);
    logic [15:0] o;
    o = 16'(off);
    if (WIDE) begin
      region = 2'(o >> `NVP_QUARTER_SHIFT);
    end else if (o < `NVP_REG0_END) begin
      region = 2'h0;
    end else if (o < `NVP_REG1_END) begin
      region = 2'h1;
    end else if (o < `NVP_REG2_END) begin
      region = 2'h2;
    end else begin
      region = 2'h3;
    end
  endfunction

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bus_state_reg <= nvp_pkg::bus_idle;
      avm_waitrequest_o <= 1'b1;
    end else if (bus_state_reg == nvp_pkg::bus_idle && req) begin
      bus_state_reg <= nvp_pkg::bus_answer;
      avm_waitrequest_o <= 1'b0;
    end else begin
      bus_state_reg <= nvp_pkg::bus_idle;
      avm_waitrequest_o <= 1'b1;
    end
  end
  always_comb begin
    rd_byte = 8'h00;
    if (avm_address_i == `NVP_CTRL_IDX) begin
      rd_byte = {3'h0, ctrl_reg};
    end else if (avm_address_i == `NVP_PROT_IDX) begin
      rd_byte = {3'h0, prot_reg};
    end else if (avm_address_i == `NVP_PUMP_IDX) begin
      rd_byte = {7'h00, pump_clock_select_reg};
    end else if (avm_address_i == `NVP_OPT_IDX) begin
      rd_byte = opt_cells_reg;
    end else if (in_array) begin
      // array bus is owned by the latches while set
      rd_byte = ctrl_reg[`NVP_B_LATCH] ? `NVP_ERASED :
          mem_reg[mem_idx];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_state_reg == nvp_pkg::bus_idle && avm_read_i) begin
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end
  assign avm_readdata_o = rdata_reg;

  // ---------------------------------------------------------------
  // program control register
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      // mode bits frozen while high voltage is applied
      if (!ctrl_reg[`NVP_B_VOLT]) begin
        ctrl_next[`NVP_B_BYTE] = wbyte[`NVP_B_BYTE];
        ctrl_next[`NVP_B_ROW] = wbyte[`NVP_B_ROW];
        ctrl_next[`NVP_B_ERASE] = wbyte[`NVP_B_ERASE];
      end
      ctrl_next[`NVP_B_LATCH] = wbyte[`NVP_B_LATCH] &&
          !(!ctrl_reg[`NVP_B_LATCH] && wbyte[`NVP_B_VOLT]);
      ctrl_next[`NVP_B_VOLT] = wbyte[`NVP_B_VOLT] &&
          wbyte[`NVP_B_LATCH] && ctrl_reg[`NVP_B_LATCH]
          && addr_seen_reg;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= `NVP_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  // latched target; frozen while voltage is on
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_seen_reg <= 1'b0;
      tgt_idx_reg <= '0;
      tgt_opt_reg <= 1'b0;
      tgt_data_reg <= 8'h00;
    end else if (!ctrl_next[`NVP_B_LATCH]) begin
      addr_seen_reg <= 1'b0;
    end else if (wr_target && ctrl_reg[`NVP_B_LATCH] &&
                 !ctrl_reg[`NVP_B_VOLT]) begin
      addr_seen_reg <= 1'b1;
      tgt_idx_reg <= mem_idx;
      tgt_opt_reg <= !in_array;
      tgt_data_reg <= wbyte;
    end
  end
  assign hv_enable_o = ctrl_reg[`NVP_B_VOLT];
  assign latch_o = ctrl_reg[`NVP_B_LATCH];

  // ---------------------------------------------------------------
  // block protect and early window
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    mode_meta_reg <= special_mode_i;
    mode_sync_reg <= mode_meta_reg;
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      early_cnt_reg <= 7'h00;
    end else if (early) begin
      early_cnt_reg <= early_cnt_reg + 7'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prot_reg <= `NVP_PROT_RESET;
    end else if (wr_prot) begin
      if (early || mode_sync_reg) begin
        prot_reg <= wbyte[4:0];
      end else begin
        prot_reg <= prot_reg | wbyte[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pump clock select
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pump_clock_select_reg <= 1'b0;
    end else if (wr_pump) begin
      pump_clock_select_reg <= wbyte[0];
    end
  end
  // 0 picks the E clock, 1 the RC oscillator
  assign pump_rc_sel_o = pump_clock_select_reg;

  // ---------------------------------------------------------------
  // option register cells and active copy
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      opt_cells_reg <= `NVP_ERASED;
    end else if (exec && tgt_opt_reg && !prot_reg[`NVP_PROT_OPT]) begin
      if (ctrl_reg[`NVP_B_ERASE]) begin
        opt_cells_reg <= `NVP_ERASED;
      end else begin
        opt_cells_reg <= opt_cells_reg & tgt_data_reg;
      end
    end
  end
  // cells are sampled only at reset, never while programming
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      opt_active_reg <= opt_cells_reg;
    end
  end

  // ---------------------------------------------------------------
  // array cells
  // ---------------------------------------------------------------
  for (genvar i = 0; i < ARRAY_BYTES; i++) begin : g_cell
    localparam logic [AW-1:0] IDX = AW'(i);
    logic hit;
    always_comb begin
      if (!ctrl_reg[`NVP_B_ERASE]) begin
        hit = (tgt_idx_reg == IDX);
      end else if (ctrl_reg[`NVP_B_BYTE]) begin
        hit = (tgt_idx_reg == IDX);
      end else if (ctrl_reg[`NVP_B_ROW]) begin
        hit = (tgt_idx_reg >> `NVP_ROW_SHIFT) ==
            (IDX >> `NVP_ROW_SHIFT);
      end else begin
        hit = 1'b1;
      end
    end
    always_ff @(posedge mclk_i) begin
      if (por_i) begin
        mem_reg[i] <= `NVP_ERASED;
      end else if (exec && !tgt_opt_reg && hit &&
                   !prot_reg[region(IDX)]) begin
        if (ctrl_reg[`NVP_B_ERASE]) begin
          mem_reg[i] <= `NVP_ERASED;
        end else begin
          mem_reg[i] <= mem_reg[i] & tgt_data_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_both_neither;
    (wr_ctrl && !ctrl_reg[`NVP_B_LATCH] && wbyte[`NVP_B_LATCH] &&
     wbyte[`NVP_B_VOLT]) |=> !latch_o && !hv_enable_o;
  endproperty
  a_both_neither: assert property (p_both_neither)
    else $error("latch and voltage set in one write");
  property p_volt_latch;
    $rose(hv_enable_o) |-> $past(latch_o) && latch_o;
  endproperty
  a_volt_latch: assert property (p_volt_latch)
    else $error("voltage rose without latch");
  property p_volt_addr;
    $rose(hv_enable_o) |-> $past(addr_seen_reg);
  endproperty
  a_volt_addr: assert property (p_volt_addr)
    else $error("voltage rose without target write");
  property p_prot_reset;
    $fell(reset_i) |-> (prot_reg == `NVP_PROT_RESET);
  endproperty
  a_prot_reset: assert property (p_prot_reset)
    else $error("protect bits not set after reset");
  property p_prot_late;
    (wr_prot && !early && !mode_sync_reg) |=>
      ((prot_reg & $past(prot_reg)) == $past(prot_reg));
  endproperty
  a_prot_late: assert property (p_prot_late)
    else $error("protect bit cleared after window");
  property p_prot_set;
    wr_prot |=> ((prot_reg & $past(wbyte[4:0])) == $past(wbyte[4:0]));
  endproperty
  a_prot_set: assert property (p_prot_set)
    else $error("protect set refused");
  property p_latched_read;
    (bus_state_reg == nvp_pkg::bus_idle && avm_read_i && in_array &&
     latch_o) |=> (avm_readdata_o[7:0] == `NVP_ERASED);
  endproperty
  a_latched_read: assert property (p_latched_read)
    else $error("array readable while latched");
  property p_clear_read_mode;
    (wr_ctrl && wbyte == 8'h00) |=> !latch_o && !hv_enable_o;
  endproperty
  a_clear_read_mode: assert property (p_clear_read_mode)
    else $error("clear did not return to read mode");
  property p_active_hold;
    !$past(reset_i) |-> $stable(opt_active_reg);
  endproperty
  a_active_hold: assert property (p_active_hold)
    else $error("option value changed outside reset");
  property p_pump_sel;
    wr_pump |=> (pump_rc_sel_o == $past(wbyte[0]));
  endproperty
  a_pump_sel: assert property (p_pump_sel)
    else $error("pump select not taken");
  property p_answer;
    (bus_state_reg == nvp_pkg::bus_idle && req) |=>
      !avm_waitrequest_o ##1 avm_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not one cycle");

endmodule

`default_nettype wire
